// [include/ptap_map.svh]
`ifndef PTAP_MAP_SVH
`define PTAP_MAP_SVH
// Sample width and trace geometry
`define PTAP_DW            16
`define PTAP_NPIX          64
`define PTAP_PIX_W         6
// Averaging and decay exponents: 2**0 .. 2**14 (1 .. 16384)
`define PTAP_LOG2_W        4
`define PTAP_LOG2_MAX      4'hE
// Interleaved sampling at or below 200 ns/div
`define PTAP_RIS_MAX_NS_DIV 32'h0000_00C8
// Modulation filter window, minimum 1 ms at one sample every 4000 ns
`define PTAP_MOD_MIN_MS    1
`define PTAP_MOD_SAMPLE_NS 4000
`define PTAP_MOD_MIN_CNT   ((`PTAP_MOD_MIN_MS*1000000+`PTAP_MOD_SAMPLE_NS-1)/`PTAP_MOD_SAMPLE_NS)
`define PTAP_MOD_MIN_LOG2  4'($clog2(`PTAP_MOD_MIN_CNT))
`define PTAP_MOD_MAX_LOG2  4'hA
`define PTAP_MOD_DEPTH     1024
`define PTAP_MOD_AW        10
`define PTAP_MOD_SUM_W     26
// Auto mode: input level below this picks the longest window
`define PTAP_AUTO_THR      16'hEC00
// Calibration table: 9 points, 3 index bits, 13 fraction bits
`define PTAP_CAL_PTS       9
`define PTAP_CAL_IDX_W     3
`define PTAP_CAL_FRAC_W    13
`endif

// [include/ptap_pkg.sv]
package ptap_pkg;
`include "ptap_map.svh"
   // Trigger sources
   typedef enum logic [1:0] {PTAP_SRC_INT, PTAP_SRC_EXT, PTAP_SRC_SLAVE} ptap_src_type;
   // Peak hold modes
   typedef enum logic [1:0] {PTAP_HOLD_TRACK, PTAP_HOLD_MANUAL, PTAP_HOLD_INF} ptap_hold_type;
   // Modulation filter modes
   typedef enum logic [1:0] {PTAP_MOD_MANUAL, PTAP_MOD_NONE, PTAP_MOD_AUTO} ptap_mod_type;
   // One pixel sample
   typedef struct packed {
      logic                   valid;
      logic [`PTAP_PIX_W-1:0] pixel;
      logic [`PTAP_DW-1:0]    value;
   } ptap_sample_type;
   // Skew trims per source
   typedef struct packed {
      logic [31:0] int_trim;
      logic [31:0] ext_trim;
      logic [31:0] slave_trim;
   } ptap_trim_type;
   // Calibration table write
   typedef struct packed {
      logic        valid;
      logic [3:0]  addr;
      logic [`PTAP_DW-1:0] data;
   } ptap_cal_wr_type;
   // Pixel readback
   typedef struct packed {
      logic [`PTAP_DW-1:0] avg_val;
      logic [`PTAP_DW-1:0] min_val;
      logic [`PTAP_DW-1:0] max_val;
      logic [`PTAP_DW-1:0] ref_val;
      logic [`PTAP_DW-1:0] corr_val;
   } ptap_view_type;
   // Registered state of the core, without the trace, window and cal memories
   typedef struct packed {
      logic [`PTAP_NPIX-1:0]    seen;
      logic                     restart_pend;
      logic [`PTAP_LOG2_W-1:0]  avg_k_q;
      ptap_hold_type            hold_q;
      logic [31:0]              tb_q;
      logic [21:0]              sweep_cnt;
      logic                     settled;
      logic [31:0]              delay_out;
      logic                     store_busy;
      logic [`PTAP_PIX_W-1:0]   store_idx;
      logic [`PTAP_MOD_AW-1:0]  mod_wr;
      logic [`PTAP_MOD_AW:0]    mod_fill;
      logic [`PTAP_LOG2_W-1:0]  mod_k_q;
      logic [`PTAP_MOD_SUM_W-1:0] mod_sum;
      logic [`PTAP_DW-1:0]      mod_out;
      logic                     mod_out_valid;
      ptap_view_type            view;
      logic                     rd_valid;
   } ptap_state_type;
endpackage

// [design/ptap_core.sv]
`timescale 1ns/1ps
//---------------------------------------------------------------
//---------------------------------------------------------------
module ptap_core
   import ptap_pkg::*;
(
   input  wire logic                     sys_clk,
   input  wire logic                     resetn,
   input  wire logic                     chan_enable,
   input  wire logic [31:0]              trig_delay,
   input  wire ptap_src_type             trig_source,
   input  wire ptap_trim_type            trims,
   output logic      [31:0]              trig_delay_applied,
   input  wire logic [`PTAP_LOG2_W-1:0]  avg_log2_req,
   input  wire ptap_hold_type            hold_mode,
   input  wire logic [`PTAP_LOG2_W-1:0]  decay_log2_req,
   input  wire logic [31:0]              timebase_ns_div,
   input  wire logic [7:0]               interleave_ratio,
   input  wire logic                     sweep_start,
   input  wire ptap_sample_type          trace_in,
   output logic                          interleaved,
   output logic                          avg_settled,
   input  wire logic                     store_cmd,
   input  wire ptap_sample_type          ref_load,
   output logic                          ref_load_ready,
   output logic                          store_busy,
   input  wire logic                     mod_valid,
   input  wire logic [`PTAP_DW-1:0]      mod_sample,
   input  wire ptap_mod_type             mod_mode,
   input  wire logic [`PTAP_LOG2_W-1:0]  mod_win_log2_req,
   output logic                          mod_out_valid,
   output logic      [`PTAP_DW-1:0]      mod_out,
   input  wire logic [15:0]              freq_code,
   input  wire ptap_cal_wr_type          cal_wr,
   input  wire logic [`PTAP_DW-1:0]      db_offset,
   input  wire logic                     rd_req,
   input  wire logic [`PTAP_PIX_W-1:0]   rd_pixel,
   output logic                          rd_valid,
   output ptap_view_type                 view
);

   //------------------------------------------------------------
   // Storage
   //------------------------------------------------------------
   logic [`PTAP_DW-1:0]   avg_mem [`PTAP_NPIX];    // Averaged trace
   logic [`PTAP_DW-1:0]   min_mem [`PTAP_NPIX];    // Minimum envelope
   logic [`PTAP_DW-1:0]   max_mem [`PTAP_NPIX];    // Maximum envelope
   logic [`PTAP_DW-1:0]   ref_mem [`PTAP_NPIX];    // Reference trace
   logic [`PTAP_DW-1:0]   mod_buf [`PTAP_MOD_DEPTH]; // Window history
   logic [`PTAP_DW-1:0]   cal_tab [`PTAP_CAL_PTS]; // Cal factor points
   ptap_state_type        state_reg;               // Registered state
   ptap_state_type        state_next;              // Next state

   //------------------------------------------------------------
   // Combinational helpers
   //------------------------------------------------------------
   logic [`PTAP_LOG2_W-1:0] avg_k;        // Clamped averaging exponent
   logic [`PTAP_LOG2_W-1:0] dec_k;        // Clamped decay exponent
   logic [`PTAP_LOG2_W-1:0] pk_k;         // Exponent for peak decay
   logic [`PTAP_LOG2_W-1:0] mod_k;        // Window exponent
   logic                    px_we;        // Pixel write enable
   logic signed [16:0]      a_old;        // Stored average
   logic signed [16:0]      x_new;        // Incoming sample
   logic signed [16:0]      a_new;        // Updated average
   logic signed [16:0]      mx_d;         // Decayed maximum
   logic signed [16:0]      mn_d;         // Decayed minimum
   logic signed [16:0]      mx_new;       // New maximum
   logic signed [16:0]      mn_new;       // New minimum
   logic                    ref_we;       // Reference write enable
   logic [`PTAP_PIX_W-1:0]  ref_wa;       // Reference write address
   logic [`PTAP_DW-1:0]     ref_wd;       // Reference write data
   logic [`PTAP_MOD_AW-1:0] mod_old_idx;  // Sample leaving the window
   logic signed [16:0]      cf_lo;        // Lower cal point
   logic signed [16:0]      cf_step;      // Cal point difference
   logic signed [30:0]      cf_prod;      // Difference times fraction
   logic signed [17:0]      cf_val;       // Interpolated factor
   logic [21:0]             sweeps_need;  // Sweeps to satisfy average

   // Exponents clamped to 16384
   assign avg_k = (avg_log2_req > `PTAP_LOG2_MAX) ? `PTAP_LOG2_MAX : avg_log2_req;
   assign dec_k = (decay_log2_req > `PTAP_LOG2_MAX) ? `PTAP_LOG2_MAX : decay_log2_req;

   //------------------------------------------------------------
   // Calibration interpolation
   //------------------------------------------------------------
   always_comb
   begin
      cf_lo   = $signed({cal_tab[freq_code[15:13]][15], cal_tab[freq_code[15:13]]});
      cf_step = 17'($signed({cal_tab[4'(freq_code[15:13]) + 4'h1][15],
                             cal_tab[4'(freq_code[15:13]) + 4'h1]}) - cf_lo);
      cf_prod = cf_step * $signed({1'b0, freq_code[`PTAP_CAL_FRAC_W-1:0]});
      cf_val  = 18'(cf_lo + (cf_prod >>> `PTAP_CAL_FRAC_W));
   end

   //------------------------------------------------------------
   // Next-state logic
   //------------------------------------------------------------
   always_comb
   begin
      state_next  = state_reg;
      px_we       = 1'b0;
      ref_we      = 1'b0;
      ref_wa      = state_reg.store_idx;
      ref_wd      = avg_mem[state_reg.store_idx];
      a_old       = $signed({avg_mem[trace_in.pixel][15], avg_mem[trace_in.pixel]});
      x_new       = $signed({trace_in.value[15], trace_in.value});
      mx_d        = $signed({max_mem[trace_in.pixel][15], max_mem[trace_in.pixel]});
      mn_d        = $signed({min_mem[trace_in.pixel][15], min_mem[trace_in.pixel]});
      pk_k        = (hold_mode == PTAP_HOLD_TRACK) ? avg_k : dec_k;
      // Skew trim of the active source added to delay
      case (trig_source)
         PTAP_SRC_EXT:   state_next.delay_out = trig_delay + trims.ext_trim;
         PTAP_SRC_SLAVE: state_next.delay_out = trig_delay + trims.slave_trim;
         default:        state_next.delay_out = trig_delay + trims.int_trim;
      endcase
      // Averaging update as shifted difference; k = 0 passes through
      a_new = 17'(a_old + ((x_new - a_old) >>> avg_k));
      // Peak decay toward the new average unless held forever
      if (hold_mode != PTAP_HOLD_INF)
      begin
         mx_d = 17'(mx_d + ((a_new - mx_d) >>> pk_k));
         mn_d = 17'(mn_d + ((a_new - mn_d) >>> pk_k));
      end
      // Envelope of the very samples that feed the average
      mx_new = (x_new > mx_d) ? x_new : mx_d;
      mn_new = (x_new < mn_d) ? x_new : mn_d;
      // First sample after a restart seeds all three values
      if (!state_reg.seen[trace_in.pixel] || (sweep_start && state_reg.restart_pend))
      begin
         a_new  = x_new;
         mx_new = x_new;
         mn_new = x_new;
      end
      // Sweep counting and restart at the next sweep
      if (sweep_start)
      begin
         if (state_reg.restart_pend)
         begin
            state_next.seen         = '0;
            state_next.sweep_cnt    = '0;
            state_next.restart_pend = 1'b0;
         end
         else if (state_reg.sweep_cnt != 22'h3F_FFFF)
         begin
            state_next.sweep_cnt = state_reg.sweep_cnt + 22'h00_0001;
         end
      end
      // Samples accepted only while the channel is on; after the restart so the set wins
      if (trace_in.valid && chan_enable)
      begin
         px_we = 1'b1;
         state_next.seen[trace_in.pixel] = 1'b1;
      end
      // Detect setting changes; a change in the restart cycle stays pending
      state_next.avg_k_q = avg_k;
      state_next.hold_q  = hold_mode;
      state_next.tb_q    = timebase_ns_div;
      if (avg_k != state_reg.avg_k_q || hold_mode != state_reg.hold_q ||
          timebase_ns_div != state_reg.tb_q)
      begin
         state_next.restart_pend = 1'b1;
      end
      state_next.settled = (state_reg.sweep_cnt >= sweeps_need) && !state_reg.restart_pend;
      // Store walk copies the averaged trace into reference memory
      if (state_reg.store_busy)
      begin
         ref_we = 1'b1;
         state_next.store_idx = state_reg.store_idx + 6'h01;
         if (state_reg.store_idx == 6'(`PTAP_NPIX - 1))
         begin
            state_next.store_busy = 1'b0;
         end
      end
      else if (store_cmd && chan_enable)
      begin
         state_next.store_busy = 1'b1;
         state_next.store_idx  = '0;
      end
      else if (ref_load.valid && chan_enable)
      begin
         ref_we = 1'b1;
         ref_wa = ref_load.pixel;
         ref_wd = ref_load.value;
      end
      // Modulation filter on its own stream
      state_next.mod_k_q       = mod_k;
      state_next.mod_out_valid = 1'b0;
      mod_old_idx = state_reg.mod_wr - `PTAP_MOD_AW'((11'h001 << mod_k) & 11'h3FF);
      if (mod_k != state_reg.mod_k_q)
      begin
         state_next.mod_fill = '0;
         state_next.mod_sum  = '0;
      end
      else if (mod_valid && chan_enable)
      begin
         state_next.mod_wr = state_reg.mod_wr + 10'h001;
         if (state_reg.mod_fill >= (11'h001 << mod_k))
         begin
            state_next.mod_sum = state_reg.mod_sum + `PTAP_MOD_SUM_W'($signed(mod_sample))
               - `PTAP_MOD_SUM_W'($signed(mod_buf[mod_old_idx]));
         end
         else
         begin
            state_next.mod_sum  = state_reg.mod_sum + `PTAP_MOD_SUM_W'($signed(mod_sample));
            state_next.mod_fill = state_reg.mod_fill + 11'h001;
         end
         state_next.mod_out       = 16'($signed(state_next.mod_sum) >>> mod_k);
         state_next.mod_out_valid = (state_next.mod_fill >= (11'h001 << mod_k));
      end
      // Pixel readback with calibration and offset applied
      state_next.rd_valid = rd_req;
      if (rd_req)
      begin
         state_next.view.avg_val  = avg_mem[rd_pixel];
         state_next.view.min_val  = min_mem[rd_pixel];
         state_next.view.max_val  = max_mem[rd_pixel];
         state_next.view.ref_val  = chan_enable ? ref_mem[rd_pixel] : 16'h0000;
         state_next.view.corr_val = 16'($signed(avg_mem[rd_pixel]) + cf_val
                                        + $signed(db_offset));
      end
   end

   //------------------------------------------------------------
   // Interleave detection and sweeps needed
   //------------------------------------------------------------
   always_comb
   begin
      interleaved = (timebase_ns_div <= `PTAP_RIS_MAX_NS_DIV);
      sweeps_need = 22'h00_0001 << avg_k;
      if (interleaved && interleave_ratio > 8'h01)
      begin
         sweeps_need = 22'((22'h00_0001 << avg_k) * interleave_ratio);
      end
   end

   //------------------------------------------------------------
   // Window length select
   //------------------------------------------------------------
   always_comb
   begin
      case (mod_mode)
         PTAP_MOD_NONE: mod_k = `PTAP_MOD_MIN_LOG2;
         PTAP_MOD_AUTO: mod_k = ($signed(mod_sample) < $signed(`PTAP_AUTO_THR)) ?
                                `PTAP_MOD_MAX_LOG2 : `PTAP_MOD_MIN_LOG2;
         default:       mod_k = (mod_win_log2_req > `PTAP_MOD_MAX_LOG2) ? `PTAP_MOD_MAX_LOG2 :
                                (mod_win_log2_req < `PTAP_MOD_MIN_LOG2) ? `PTAP_MOD_MIN_LOG2 :
                                mod_win_log2_req;
      endcase
   end

   //------------------------------------------------------------
   // State register
   //------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         state_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   //------------------------------------------------------------
   // Memory writes
   //------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (px_we)
      begin
         avg_mem[trace_in.pixel] <= a_new[15:0];
         max_mem[trace_in.pixel] <= mx_new[15:0];
         min_mem[trace_in.pixel] <= mn_new[15:0];
      end
      if (ref_we)
      begin
         ref_mem[ref_wa] <= ref_wd;
      end
      if (mod_valid && chan_enable && mod_k == state_reg.mod_k_q)
      begin
         mod_buf[state_reg.mod_wr] <= mod_sample;
      end
      if (cal_wr.valid && cal_wr.addr < 4'(`PTAP_CAL_PTS))
      begin
         cal_tab[cal_wr.addr] <= cal_wr.data;
      end
   end

   //------------------------------------------------------------
   // Outputs
   //------------------------------------------------------------
   assign trig_delay_applied = state_reg.delay_out;
   assign avg_settled        = state_reg.settled;
   assign store_busy         = state_reg.store_busy;
   assign ref_load_ready     = !state_reg.store_busy && !store_cmd && chan_enable;
   assign mod_out_valid      = state_reg.mod_out_valid;
   assign mod_out            = state_reg.mod_out;
   assign rd_valid           = state_reg.rd_valid;
   assign view               = state_reg.view;

endmodule // ptap_core

// [tb/ptap_checker.sv]
`timescale 1ns/1ps
// ---------------------------------------------
// Port checker of the trace post-processing core
// ---------------------------------------------
module ptap_checker
   import ptap_pkg::*;
(
   input wire logic          sys_clk,
   input wire logic          resetn,
   input wire logic          chan_enable,
   input wire logic [31:0]   trig_delay,
   input wire ptap_src_type  trig_source,
   input wire ptap_trim_type trims,
   input wire logic [31:0]   trig_delay_applied,
   input wire logic [31:0]   timebase_ns_div,
   input wire logic          interleaved,
   input wire logic          store_cmd,
   input wire logic          store_busy,
   input wire logic          ref_load_ready,
   input wire logic          mod_valid,
   input wire logic          mod_out_valid,
   input wire logic          rd_req,
   input wire logic          rd_valid,
   input wire ptap_view_type view
);
   logic [1:0]  live_reg;  // Two cycles since reset release
   logic [7:0]  run_reg;   // Length of the current busy run
   logic [31:0] trim_sel;  // Trim of the active source
   // Helper counters
   always_ff @(posedge sys_clk)
   begin
      live_reg <= resetn ? {live_reg[0], 1'b1} : 2'h0;
      run_reg  <= (resetn && store_busy) ? run_reg + 8'h01 : 8'h00;
   end
   // Trim picked by source
   always_comb
   begin
      case (trig_source)
         PTAP_SRC_EXT:   trim_sel = trims.ext_trim;
         PTAP_SRC_SLAVE: trim_sel = trims.slave_trim;
         default:        trim_sel = trims.int_trim;
      endcase
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn || !live_reg[1]);
   // Copy accepted
   sequence store_go;
      store_cmd && !store_busy && chan_enable;
   endsequence
   // Readback while the channel stays off
   sequence rd_off;
      rd_req && !chan_enable ##1 !chan_enable;
   endsequence
   chk_delay_trim: assert property (
      1'b1 |=> trig_delay_applied == $past(trig_delay) + $past(trim_sel))
      else $error("applied delay wrong");
   chk_interleave_map: assert property (
      interleaved == (timebase_ns_div <= 32'h0000_00C8))
      else $error("interleave flag wrong");
   chk_busy_start: assert property (store_go |=> store_busy)
      else $error("store not started");
   chk_busy_len: assert property ($fell(store_busy) |-> run_reg == 8'h40)
      else $error("busy length wrong");
   chk_load_ready: assert property (
      ref_load_ready == (!store_busy && !store_cmd && chan_enable))
      else $error("load ready wrong");
   chk_rd_answer: assert property (1'b1 |=> rd_valid == $past(rd_req))
      else $error("read answer wrong");
   chk_view_hold: assert property (!rd_req |=> $stable(view))
      else $error("view changed");
   chk_ref_off: assert property (rd_off |-> rd_valid && view.ref_val == 16'h0000)
      else $error("reference shown while off");
   chk_mod_cause: assert property (mod_out_valid |-> $past(mod_valid && chan_enable))
      else $error("filter output without sample");
endmodule // ptap_checker

bind ptap_core ptap_checker i_chk (.sys_clk, .resetn, .chan_enable, .trig_delay, .trig_source,
   .trims, .trig_delay_applied, .timebase_ns_div, .interleaved, .store_cmd, .store_busy,
   .ref_load_ready, .mod_valid, .mod_out_valid, .rd_req, .rd_valid, .view);

// [tb/ptap_det_model.sv]
`timescale 1ns/1ps
// ---------------------------------------------
// Detector sample source
// ---------------------------------------------
module ptap_det_model
   import ptap_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        det_go,
   input  wire logic [5:0]  det_pix,
   input  wire logic [15:0] det_val,
   output ptap_sample_type  trace_in
);
   initial trace_in = '0;
   // One sample per request; idle lines toggle so stale data is never reused
   always @(posedge sys_clk)
   begin
      trace_in.valid <= det_go;
      trace_in.pixel <= det_go ? det_pix : ~trace_in.pixel;
      trace_in.value <= det_go ? det_val : ~trace_in.value;
   end
endmodule // ptap_det_model

// [tb/testbench.sv]
`timescale 1ns/1ps
`define CLK @(posedge sys_clk)
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fails++; \
   $display("CHECK FAILED %0t got %0h exp %0h", $time, (g), (e)); end end
// ---------------------------------------------
// Self-checking bench
// ---------------------------------------------
module testbench;
   import ptap_pkg::*;
   logic sys_clk = 0, resetn = 0, chan_enable = 1, sweep_start = 0, store_cmd = 0;
   logic mod_valid = 0, rd_req = 0, det_go = 0;
   logic [31:0] trig_delay = 0, timebase_ns_div = 32'h0000_03E8, trig_delay_applied;
   logic [3:0] avg_log2_req = 0, decay_log2_req = 0, mod_win_log2_req = 0;
   logic [15:0] freq_code = 0, db_offset = 0, mod_sample = 0, det_val = 0, mod_out;
   logic [7:0] interleave_ratio = 8'h01;
   logic [5:0] rd_pixel = 0, det_pix = 0;
   ptap_src_type    trig_source = PTAP_SRC_INT;
   ptap_trim_type   trims = '0;
   ptap_hold_type   hold_mode = PTAP_HOLD_TRACK;
   ptap_mod_type    mod_mode = PTAP_MOD_NONE;
   ptap_sample_type trace_in, ref_load = '0;
   ptap_cal_wr_type cal_wr = '0;
   ptap_view_type   view;
   logic interleaved, avg_settled, ref_load_ready, store_busy, mod_out_valid, rd_valid;
   int fails = 0, samples_checked = 0, cyc = 0, i, c;
   int pa[64], pn[64], px[64], cal[9];  // Model average, minimum, maximum, cal points
   bit seen[64];                        // Model pixel seeded since restart
   always #2 sys_clk = ~sys_clk;
   // Hang guard
   always `CLK
   begin
      cyc++;
      if (cyc == 20000)
      begin
         fails++;
         stop_test();
      end
   end
   ptap_core i_dut (.sys_clk, .resetn, .chan_enable, .trig_delay, .trig_source, .trims,
      .trig_delay_applied, .avg_log2_req, .hold_mode, .decay_log2_req, .timebase_ns_div,
      .interleave_ratio, .sweep_start, .trace_in, .interleaved, .avg_settled, .store_cmd,
      .ref_load, .ref_load_ready, .store_busy, .mod_valid, .mod_sample, .mod_mode,
      .mod_win_log2_req, .mod_out_valid, .mod_out, .freq_code, .cal_wr, .db_offset, .rd_req,
      .rd_pixel, .rd_valid, .view);
   ptap_det_model i_det (.sys_clk, .det_go, .det_pix, .det_val, .trace_in);
   // Pixel model: seed, exponential average, peak decay then envelope
   task automatic mdl(int p, int x);
      int a;
      int d;
      d = (hold_mode == PTAP_HOLD_MANUAL) ? decay_log2_req : avg_log2_req;
      a = seen[p] ? pa[p] + ((x - pa[p]) >>> avg_log2_req) : x;
      if (!seen[p])
      begin
         px[p] = x;
         pn[p] = x;
      end
      else if (hold_mode != PTAP_HOLD_INF)
      begin
         px[p] = px[p] + ((a - px[p]) >>> d);
         pn[p] = pn[p] + ((a - pn[p]) >>> d);
      end
      seen[p] = 1;
      pa[p] = a;
      px[p] = (x > px[p]) ? x : px[p];
      pn[p] = (x < pn[p]) ? x : pn[p];
   endtask
   task automatic samp(int p, logic [15:0] v);
      `CLK det_go <= 1'b1;
      det_pix <= 6'(p);
      det_val <= v;
      `CLK det_go <= 1'b0;
      if (chan_enable) mdl(p, $signed(v));
   endtask
   task automatic sweep();
      `CLK sweep_start <= 1'b1;
      `CLK sweep_start <= 1'b0;
   endtask
   task automatic cfg(logic [3:0] k, ptap_hold_type h, logic [3:0] dk);
      `CLK avg_log2_req <= k;
      hold_mode <= h;
      decay_log2_req <= dk;
      repeat (2) `CLK;
      sweep();
      seen = '{default: 0};
   endtask
   task automatic rd(int p);
      `CLK rd_req <= 1'b1;
      rd_pixel <= 6'(p);
      `CLK rd_req <= 1'b0;
      #1;
      `CHK(rd_valid, 1'b1)
   endtask
   task automatic rdchk(int p);
      rd(p);
      `CHK(view.avg_val, 16'(pa[p]))
      `CHK(view.max_val, 16'(px[p]))
      `CHK(view.min_val, 16'(pn[p]))
   endtask
   // Window of 2**k samples must answer exactly after the last one
   // Level 0 any value, 1 positive, 2 below the auto threshold
   task automatic modrun(ptap_mod_type m, logic [3:0] r, int k, int lvl);
      int s;
      logic [15:0] v;
      `CLK mod_mode <= m;
      mod_win_log2_req <= r;
      mod_sample <= (lvl == 2) ? 16'h8000 : 16'h0000;
      repeat (3) `CLK;
      s = 0;
      for (int j = 0; j <= (1 << k); j++)
      begin
         v = (lvl == 1) ? 16'($urandom % 16'h4000) :
             (lvl == 2) ? 16'(16'h8000 + $urandom % 16'h6000) : 16'($urandom);
         `CLK mod_valid <= (j < (1 << k));
         mod_sample <= v;
         if (j < (1 << k)) s += $signed(v);
         #1;
         if (j > 0) `CHK(mod_out_valid, j == (1 << k))
      end
      `CHK(mod_out, 16'(s >>> k))
   endtask
   task automatic stop_test();
      if (fails == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // Main sequence
   initial
   begin
      i = $urandom(32'h22FD4AB2);
      repeat (20) `CLK;
      resetn <= 1'b1;
      for (i = 0; i < 3; i++)
      begin
         `CLK trig_source <= ptap_src_type'(i);
         trig_delay <= $urandom;
         trims <= {$urandom, $urandom, $urandom};
         `CLK #1;
         `CHK(trig_delay_applied, 32'(trig_delay + trims[95 - 32 * i -: 32]))
      end
      for (i = 200; i < 202; i++)
      begin
         `CLK timebase_ns_div <= i;
         #1;
         `CHK(interleaved, i == 200)
      end
      `CLK timebase_ns_div <= 32'h0000_0064;
      interleave_ratio <= 8'h03;
      cfg(4'h2, PTAP_HOLD_TRACK, 4'h0);
      samp(5, 16'h0400);
      samp(5, 16'h0000);
      samp(5, 16'h0800);
      rdchk(5);
      cfg(4'h0, PTAP_HOLD_MANUAL, 4'h3);
      samp(5, 16'h0800);
      samp(5, 16'h0000);
      samp(5, 16'h0100);
      rdchk(5);
      cfg(4'h0, PTAP_HOLD_INF, 4'h0);
      for (i = 0; i < 4; i++) samp(9, 16'($urandom));
      rdchk(9);
      `CLK chan_enable <= 1'b0;
      samp(9, 16'h7FFF);
      rd(9);
      `CHK(view.ref_val, 16'h0000)
      `CLK chan_enable <= 1'b1;
      rdchk(9);
      cfg(4'h1, PTAP_HOLD_TRACK, 4'h0);
      #1;
      `CHK(avg_settled, 1'b0)
      repeat (5) sweep();
      repeat (2) `CLK;
      #1;
      `CHK(avg_settled, 1'b0)
      sweep();
      repeat (2) `CLK;
      #1;
      `CHK(avg_settled, 1'b1)
      samp(5, 16'h1234);
      `CLK store_cmd <= 1'b1;
      `CLK store_cmd <= 1'b0;
      #1;
      `CHK(store_busy, 1'b1)
      repeat (64) `CLK;
      #1;
      `CHK(store_busy, 1'b0)
      rd(5);
      `CHK(view.ref_val, 16'h1234)
      i = $urandom;
      `CLK ref_load <= {1'b1, 6'h0B, i[15:0]};
      `CLK ref_load.valid <= 1'b0;
      rd(11);
      `CHK(view.ref_val, i[15:0])
      for (i = 0; i < 9; i++)
      begin
         cal[i] = $signed(16'($urandom));
         `CLK cal_wr <= {1'b1, 4'(i), 16'(cal[i])};
      end
      `CLK cal_wr <= '0;
      freq_code <= {3'h2, 13'($urandom)};
      db_offset <= 16'($urandom);
      rd(5);
      c = ((cal[3] - cal[2]) * int'(freq_code[12:0])) >>> 13;
      `CHK(view.corr_val, 16'(pa[5] + cal[2] + c + $signed(db_offset)))
      modrun(PTAP_MOD_NONE, 4'h0, 8, 1'b0);
      modrun(PTAP_MOD_MANUAL, 4'h9, 9, 1'b0);
      modrun(PTAP_MOD_AUTO, 4'h0, 8, 1'b1);
      modrun(PTAP_MOD_AUTO, 4'h0, 10, 2);
      stop_test();
   end
endmodule // testbench
